// ===== hdl/mmio_port_unit.v
// multi-mode i/o port unit: ports a, b, c with pin modes, alternate
// functions, port interrupts on a and b, and the nmi alternate input.
// assumes the core drives single-cycle read/write strobes on clock and
// that pads resolve pin_out/pin_oe/pin_pullup into the wire level.
//
// Functional notes
// - three ports, twenty-two lines, i/o or peripheral
// - each pin picks its role independently
// - reset leaves every pin high-impedance input
// - pull-up, option, direction select eight modes
// - pull-up and option captured on direction write
// - pin levels read at addresses 00h-02h
// - inputs read pins, outputs read buffer
// - output write updates buffer and output pins
// - buffer ignored for input or interrupt pins
// - interrupt mode only on ports a, b
// - port interrupt is or of pins
// - interrupt pins stay readable through input register
// - polarity register picks rising or falling edge
// - alternate register selects peripheral per pin
// - direction picks peripheral input or output function
// - nmi only with a7 alternate and input
// - peripheral override forces pin configuration
// - register bit n controls pin n
// - direction 0 input, 1 output
// - pull-up bit 1 enables pull-up
// - alternate bit 1 connects peripheral
`timescale 1ns/10ps
`default_nettype none
`include "mmio_consts.vh"

module mmio_port_unit (
  input wire clock,
  input wire rst_b,
  // input register space
  input wire [7:0] in_rd_addr,
  output reg [7:0] in_rd_data,
  // output register space
  input wire out_wr_en,
  input wire [7:0] out_wr_addr,
  input wire [7:0] out_wr_data,
  // configuration register space
  input wire cfg_wr_en,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wr_data,
  output reg [7:0] cfg_rd_data,
  // pins, port a in bits 7:0, b in 15:8, c in 23:16
  input wire [`MMIO_ALL_W-1:0] pin_in,
  output reg [`MMIO_ALL_W-1:0] pin_out,
  output reg [`MMIO_ALL_W-1:0] pin_oe,
  output reg [`MMIO_ALL_W-1:0] pin_pullup,
  // peripheral side
  input wire [`MMIO_ALL_W-1:0] periph_out,
  output reg [`MMIO_ALL_W-1:0] periph_in,
  input wire [`MMIO_ALL_W-1:0] ovr_en,
  input wire [`MMIO_ALL_W-1:0] ovr_dir,
  input wire [`MMIO_ALL_W-1:0] ovr_pu,
  input wire [`MMIO_ALL_W-1:0] ovr_opt,
  // interrupts
  output reg [`MMIO_IRQ_PORTS-1:0] port_irq,
  output wire nmi_req
);

  // configuration byte address of one register of one port
  function [7:0] cfg_reg;
    input [7:0] port;
    input [7:0] ofs;
    begin
      cfg_reg = `MMIO_CFG_BASE + port * `MMIO_CFG_STRIDE + ofs;
    end
  endfunction

  // per-pin drive decode; used for the enable only
  function [7:0] drive_oe;
    input [7:0] dir;
    input [7:0] opt;
    input [7:0] val;
    begin
      // open drain drives only a low; push-pull always drives
      drive_oe = dir & (~opt | ~val);
    end
  endfunction

  wire [`MMIO_ALL_W-1:0] pin_s;
  reg [7:0] pol;

  // flat views of each port for the read multiplexers, plus per-port edge flags
  wire [`MMIO_ALL_W-1:0] pu_stage_all;
  wire [`MMIO_ALL_W-1:0] opt_stage_all;
  wire [`MMIO_ALL_W-1:0] dir_all;
  wire [`MMIO_ALL_W-1:0] alt_all;
  wire [`MMIO_ALL_W-1:0] view_all;
  wire [`MMIO_NUM_PORTS-1:0] edge_any;

  mmio_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d(pin_in),
    .q(pin_s)
  );

  always @(posedge clock) begin
    if (!rst_b) begin
      pol <= `MMIO_POL_RESET;
    end else if (cfg_wr_en && cfg_addr == `MMIO_POL_ADDR) begin
      pol <= cfg_wr_data & `MMIO_POL_MASK;
    end
  end

  genvar p;
  generate
    for (p = 0; p < `MMIO_NUM_PORTS; p = p + 1) begin : g_port
      localparam [7:0] PIDX = p;
      // port c has six lines; its upper bits are absent and read zero
      localparam [7:0] PMASK = (p == 2) ? `MMIO_MASK_C : `MMIO_MASK_AB;
      localparam IRQ_OK = (p < `MMIO_IRQ_PORTS);

      reg [7:0] pu_stage;
      reg [7:0] opt_stage;
      reg [7:0] pu_act;
      reg [7:0] opt_act;
      reg [7:0] dir_act;
      reg [7:0] alt_sel;
      reg [7:0] out_buf;
      reg [7:0] prev_lvl;

      wire [7:0] s_lvl = pin_s[8*p +: 8];
      wire [7:0] o_en = ovr_en[8*p +: 8];

      // a forcing peripheral wins over the user setting per pin
      wire [7:0] eff_dir = (o_en & ovr_dir[8*p +: 8]) | (~o_en & dir_act);
      wire [7:0] eff_pu = (o_en & ovr_pu[8*p +: 8]) | (~o_en & pu_act);
      wire [7:0] eff_opt = (o_en & ovr_opt[8*p +: 8]) | (~o_en & opt_act);

      // peripheral drives instead of the buffer when selected
      wire [7:0] drv = (alt_sel & periph_out[8*p +: 8]) | (~alt_sel & out_buf);
      wire [7:0] irq_pins = IRQ_OK ? (eff_opt & ~eff_dir & ~alt_sel) : `MMIO_ZERO_BYTE;
      wire [7:0] rise = s_lvl & ~prev_lvl & irq_pins;
      wire [7:0] fall = ~s_lvl & prev_lvl & irq_pins;

      always @(posedge clock) begin
        if (!rst_b) begin
          pu_stage <= `MMIO_RESET_BYTE;
          opt_stage <= `MMIO_RESET_BYTE;
          pu_act <= `MMIO_RESET_BYTE;
          opt_act <= `MMIO_RESET_BYTE;
          dir_act <= `MMIO_RESET_BYTE;
          alt_sel <= `MMIO_RESET_BYTE;
          out_buf <= `MMIO_RESET_BYTE;
          prev_lvl <= `MMIO_RESET_BYTE;
        end else begin
          if (cfg_wr_en && cfg_addr == cfg_reg(PIDX, `MMIO_OFS_PULLUP)) begin
            pu_stage <= cfg_wr_data & PMASK;
          end
          if (cfg_wr_en && cfg_addr == cfg_reg(PIDX, `MMIO_OFS_OPTION)) begin
            opt_stage <= cfg_wr_data & PMASK;
          end
          // staged pull-up and option go live only with direction
          if (cfg_wr_en && cfg_addr == cfg_reg(PIDX, `MMIO_OFS_DIR)) begin
            dir_act <= cfg_wr_data & PMASK;
            pu_act <= pu_stage;
            opt_act <= opt_stage;
          end
          if (cfg_wr_en && cfg_addr == cfg_reg(PIDX, `MMIO_OFS_ALT)) begin
            alt_sel <= cfg_wr_data & PMASK;
          end
          if (out_wr_en && out_wr_addr == PIDX) begin
            out_buf <= out_wr_data & PMASK;
          end
          prev_lvl <= s_lvl;
        end
      end

      // pad controls registered so pads never see decode glitches
      always @(posedge clock) begin
        if (!rst_b) begin
          pin_out[8*p +: 8] <= `MMIO_ZERO_BYTE;
          pin_oe[8*p +: 8] <= `MMIO_ZERO_BYTE;
          pin_pullup[8*p +: 8] <= `MMIO_ZERO_BYTE;
          periph_in[8*p +: 8] <= `MMIO_ZERO_BYTE;
        end else begin
          // buffer reaches only output pins; others ignore it
          pin_out[8*p +: 8] <= drv & ~eff_opt & eff_dir & PMASK;
          pin_oe[8*p +: 8] <= drive_oe(eff_dir, eff_opt, drv) & PMASK;
          pin_pullup[8*p +: 8] <= eff_pu & PMASK;
          // cleared direction picks the peripheral input function
          periph_in[8*p +: 8] <= s_lvl & alt_sel & ~eff_dir & PMASK;
        end
      end

      assign pu_stage_all[8*p +: 8] = pu_stage;
      assign opt_stage_all[8*p +: 8] = opt_stage;
      assign dir_all[8*p +: 8] = dir_act;
      assign alt_all[8*p +: 8] = alt_sel;
      // interrupt pins are inputs, so they read their level too
      assign view_all[8*p +: 8] = ((eff_dir & out_buf) | (~eff_dir & s_lvl)) & PMASK;
      // polarity bit chooses which edge counts for the port
      assign edge_any[p] = pol[p] ? (|rise) : (|fall);
    end
  endgenerate

  // one-cycle request per qualifying edge; port c never raises one
  always @(posedge clock) begin
    if (!rst_b) begin
      port_irq <= {`MMIO_IRQ_PORTS{1'b0}};
    end else begin
      port_irq <= edge_any[`MMIO_IRQ_PORTS-1:0];
    end
  end

  // a7 passes only as an alternate input, which periph_in already gates
  assign nmi_req = periph_in[`MMIO_NMI_BIT];

  // input register reads; unmapped addresses return zero
  always @(posedge clock) begin
    if (!rst_b) begin
      in_rd_data <= `MMIO_ZERO_BYTE;
    end else begin
      case (in_rd_addr)
        `MMIO_IO_PORT_A: in_rd_data <= view_all[7:0];
        `MMIO_IO_PORT_B: in_rd_data <= view_all[15:8];
        `MMIO_IO_PORT_C: in_rd_data <= view_all[23:16];
        default: in_rd_data <= `MMIO_ZERO_BYTE;
      endcase
    end
  end

  // configuration reads return the written value less absent bits, staged or live
  reg [7:0] next_cfg_rd;
  integer k;
  always @* begin
    next_cfg_rd = `MMIO_ZERO_BYTE;
    for (k = 0; k < `MMIO_NUM_PORTS; k = k + 1) begin
      if (cfg_addr == cfg_reg(k[7:0], `MMIO_OFS_PULLUP)) begin
        next_cfg_rd = pu_stage_all[8*k +: 8];
      end
      if (cfg_addr == cfg_reg(k[7:0], `MMIO_OFS_OPTION)) begin
        next_cfg_rd = opt_stage_all[8*k +: 8];
      end
      if (cfg_addr == cfg_reg(k[7:0], `MMIO_OFS_DIR)) begin
        next_cfg_rd = dir_all[8*k +: 8];
      end
      if (cfg_addr == cfg_reg(k[7:0], `MMIO_OFS_ALT)) begin
        next_cfg_rd = alt_all[8*k +: 8];
      end
    end
    if (cfg_addr == `MMIO_POL_ADDR) begin
      next_cfg_rd = pol;
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      cfg_rd_data <= `MMIO_ZERO_BYTE;
    end else begin
      cfg_rd_data <= next_cfg_rd;
    end
  end

endmodule // mmio_port_unit

`default_nettype wire

// ===== hdl/mmio_consts.vh
// constants for the multi-mode i/o port unit
// assumes an 8-bit core with separate input, output and configuration spaces
`ifndef MMIO_CONSTS_VH
`define MMIO_CONSTS_VH

`define MMIO_NUM_PORTS 3
`define MMIO_IRQ_PORTS 2
`define MMIO_PORT_W 8
`define MMIO_ALL_W 24

// input and output register space: one byte address per port
`define MMIO_IO_PORT_A 8'h00
`define MMIO_IO_PORT_B 8'h01
`define MMIO_IO_PORT_C 8'h02

// configuration space: four registers per port from the base
`define MMIO_CFG_BASE 8'h18
`define MMIO_CFG_STRIDE 8'h04
`define MMIO_OFS_PULLUP 8'h00
`define MMIO_OFS_OPTION 8'h01
`define MMIO_OFS_DIR 8'h02
`define MMIO_OFS_ALT 8'h03
`define MMIO_POL_ADDR 8'h24

// bit 0 port a, bit 1 port b; 1 = rising edge
`define MMIO_POL_MASK 8'h03
`define MMIO_POL_RESET 8'h00

`define MMIO_RESET_BYTE 8'h00
`define MMIO_MASK_AB 8'hff
`define MMIO_MASK_C 8'h3f
`define MMIO_NMI_BIT 7
`define MMIO_ZERO_BYTE 8'h00

`endif

// ===== hdl/mmio_sync.v
// two-stage synchroniser for all port pin inputs
// assumes pins are asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
`include "mmio_consts.vh"

module mmio_sync (
  input wire clock,
  input wire rst_b,
  input wire [`MMIO_ALL_W-1:0] d,
  output reg [`MMIO_ALL_W-1:0] q
);

  reg [`MMIO_ALL_W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (!rst_b) begin
      meta <= {`MMIO_NUM_PORTS{`MMIO_ZERO_BYTE}};
      q <= {`MMIO_NUM_PORTS{`MMIO_ZERO_BYTE}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // mmio_sync

`default_nettype wire

// ===== sim/mmio_pin_model.sv
// pad-side model: outside drivers, pull-ups and floating lines
// assumes the unit's pin outputs settle the pad level each cycle
`timescale 1ns/10ps
`default_nettype none
module mmio_pin_model (
  input wire clock,
  input wire [23:0] pin_out,
  input wire [23:0] pin_oe,
  input wire [23:0] pin_pullup,
  input wire [23:0] ext_val,
  input wire [23:0] ext_oe,
  output wire [23:0] pin_in
);
  reg [23:0] last = 24'h00_0000;
  // a floating line toggles so a stale level never reads as a match
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
    | (~pin_oe & ~ext_oe & (pin_pullup | ~last));
  always @(posedge clock) begin
    last <= pin_in;
  end
endmodule // mmio_pin_model
`default_nettype wire

// ===== sim/mmio_port_asserts.sv
// assertions on the port unit register and pin ports
// assumes a bind onto mmio_port_unit, one clock domain
`timescale 1ns/10ps
`default_nettype none
module mmio_port_asserts (
  input wire clock,
  input wire rst_b,
  input wire [7:0] in_rd_addr,
  input wire [7:0] in_rd_data,
  input wire out_wr_en,
  input wire [7:0] out_wr_addr,
  input wire [7:0] out_wr_data,
  input wire cfg_wr_en,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wr_data,
  input wire [7:0] cfg_rd_data,
  input wire [23:0] pin_out,
  input wire [23:0] pin_oe,
  input wire [23:0] pin_pullup
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_wr_a;
    out_wr_en && out_wr_addr == 8'h00 ##1 !out_wr_en;
  endsequence
  sequence s_pu_only;
    !cfg_wr_en ##1 cfg_wr_en && cfg_addr == 8'h18 ##1 !cfg_wr_en [*2];
  endsequence
  // only driven pins are checked: floating ones carry no known level
  sequence s_rd_a;
    (in_rd_addr == 8'h00 && pin_oe[3:2] == 2'h3 && $stable(pin_out[3:2])) [*3];
  endsequence
  a_reset_idle: assert property ($rose(rst_b) |-> !(|{pin_oe, pin_pullup, pin_out}))
    else $error("pins not idle after reset");
  a_top_c_idle: assert property (pin_oe[23:22] == 2'h0 && pin_pullup[23:22] == 2'h0)
    else $error("absent port c line active");
  a_unmapped_rd: assert property (in_rd_addr > 8'h02 |=> in_rd_data == 8'h00)
    else $error("unmapped input read not zero");
  a_pu_staged: assert property (s_pu_only |-> $stable(pin_pullup))
    else $error("pull-up live before direction write");
  a_cfg_echo: assert property (cfg_wr_en && cfg_addr == 8'h18 ##1 cfg_addr == 8'h18
    |=> cfg_rd_data == $past(cfg_wr_data, 2)) else $error("pull-up readback wrong");
  a_pol_masked: assert property (cfg_wr_en && cfg_addr == 8'h24 ##1 cfg_addr == 8'h24
    |=> cfg_rd_data[7:2] == 6'h00) else $error("polarity spare bits set");
  a_out_lag: assert property (s_wr_a ##1 (pin_oe[3:2] == 2'h3 && $stable(pin_oe[3:2]))
    |-> ((pin_out[7:0] ^ $past(out_wr_data, 2)) & 8'h0c) == 8'h00) else $error("pin drive late");
  a_rd_buffer: assert property (s_rd_a |-> in_rd_data[3:2] == pin_out[3:2])
    else $error("output pin read wrong");
endmodule // mmio_port_asserts
bind mmio_port_unit mmio_port_asserts u_chk (.clock(clock), .rst_b(rst_b),
  .in_rd_addr(in_rd_addr), .in_rd_data(in_rd_data), .out_wr_en(out_wr_en),
  .out_wr_addr(out_wr_addr), .out_wr_data(out_wr_data), .cfg_wr_en(cfg_wr_en),
  .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

// ===== sim/test_multi_mode_io_port_unit.sv
// self-checking bench for the multi-mode i/o port unit
// assumes the pad model resolves every pin level
`timescale 1ns/10ps
`default_nettype none
module test_multi_mode_io_port_unit;
  reg clock = 1'b0, rst_b = 1'b0, ow = 1'b0, ce = 1'b0;
  reg [7:0] ra = 8'h00, oa = 8'h00, od = 8'h00, ca = 8'h00, cd = 8'h00, i;
  reg [23:0] ev = 24'h00_0000, eo = 24'h00_0000, po = 24'h00_0000;
  reg [23:0] ven = 24'h00_0000, vdir = 24'h00_0000;
  wire [7:0] rd, crd;
  wire [23:0] pin, pout, poe, ppu, pper;
  wire [1:0] irq;
  wire nmi;
  integer bad_count = 0, check_count = 0, na = 0, nb = 0;
  mmio_port_unit dut (.clock(clock), .rst_b(rst_b), .in_rd_addr(ra), .in_rd_data(rd),
    .out_wr_en(ow), .out_wr_addr(oa), .out_wr_data(od), .cfg_wr_en(ce), .cfg_addr(ca),
    .cfg_wr_data(cd), .cfg_rd_data(crd), .pin_in(pin), .pin_out(pout), .pin_oe(poe),
    .pin_pullup(ppu), .periph_out(po), .periph_in(pper), .ovr_en(ven), .ovr_dir(vdir),
    .ovr_pu(24'h00_0000), .ovr_opt(24'h00_0000), .port_irq(irq), .nmi_req(nmi));
  mmio_pin_model pads (.clock(clock), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .ext_val(ev), .ext_oe(eo), .pin_in(pin));
  always #2 clock = ~clock;
  // sampling on the rising edge counts each one-cycle pulse once
  always @(posedge clock) begin
    na <= na + (irq[0] === 1'b1);
    nb <= nb + (irq[1] === 1'b1);
  end
  task check(input [23:0] got, input [23:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input c, input [7:0] a, input [7:0] d);
    begin
      @(negedge clock);
      {ca, cd, oa, od} = {a, d, a, d};
      {ce, ow} = {c, ~c};
      @(negedge clock);
      {ce, ow} = 2'h0;
      repeat (3) @(negedge clock);
    end
  endtask
  // masked so floating bits never decide a compare
  task rc(input c, input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      @(negedge clock);
      if (c) ca = a;
      else ra = a;
      repeat (2) @(negedge clock);
      check((c ? crd : rd) & m, e & m);
    end
  endtask
  task results;
    begin
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    bad_count = bad_count + 1;
    results;
  end
  initial begin
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    check(poe | ppu | pout, 24'h00_0000);
    for (i = 8'h18; i < 8'h25; i = i + 8'h01) begin
      rc(1'b1, i, 8'h00, 8'hff);
    end
    wr(1'b1, 8'h18, 8'hf0);
    check(ppu, 24'h00_0000);
    rc(1'b1, 8'h18, 8'hf0, 8'hff);
    wr(1'b1, 8'h1a, 8'h0f);
    check({ppu[7:0], poe[7:0]}, 24'h00_f00f);
    wr(1'b0, 8'h00, 8'ha5);
    check({poe[7:0], pout[3:0]}, 24'h00_00f5);
    eo[7:4] = 4'hf;
    ev[7:4] = 4'h6;
    rc(1'b0, 8'h00, 8'h65, 8'hff);
    wr(1'b1, 8'h19, 8'h03);
    wr(1'b1, 8'h1a, 8'h0f);
    check({poe[3:0], pout[3:0]}, 24'h00_00e4);
    ev[7] = 1'b1;
    wr(1'b1, 8'h1b, 8'h80);
    check({pper[7], nmi}, 24'h00_0003);
    po[7] = 1'b1;
    wr(1'b1, 8'h1a, 8'h8f);
    check({nmi, poe[7], pout[7]}, 24'h00_0003);
    {eo[8], ev[8]} = 2'h3;
    wr(1'b1, 8'h1d, 8'h01);
    wr(1'b1, 8'h1e, 8'h00);
    wr(1'b0, 8'h01, 8'hff);
    check(poe[15:8], 24'h00_0000);
    ev[8] = 1'b0;
    repeat (8) @(negedge clock);
    check(nb, 24'h00_0001);
    wr(1'b1, 8'h24, 8'hff);
    rc(1'b1, 8'h24, 8'h03, 8'hff);
    ev[8] = 1'b1;
    rc(1'b0, 8'h01, 8'h01, 8'h01);
    wr(1'b1, 8'h20, 8'hff);
    rc(1'b1, 8'h20, 8'h3f, 8'hff);
    eo[16] = 1'b1;
    wr(1'b1, 8'h21, 8'h01);
    wr(1'b1, 8'h22, 8'h00);
    check(ppu[23:16], 24'h00_003f);
    ev[16] = 1'b1;
    repeat (8) @(negedge clock);
    check({nb[3:0], na[3:0]}, 24'h00_0020);
    rc(1'b0, 8'h05, 8'h00, 8'hff);
    {ven[16], vdir[16]} = 2'h3;
    repeat (4) @(negedge clock);
    check(poe[16], 24'h00_0001);
    results;
  end
endmodule // test_multi_mode_io_port_unit
`default_nettype wire
